// ---- verilog/msm_top.sv ----
// msm_top: memory select mapping with ahb-lite configuration registers
// assumes host bus pins are asynchronous to hclk; registers on ahb-lite
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps

module msm_top
   import msm_pkg::*;
(
   input  wire logic                  hclk,               // bus clock
   input  wire logic                  hresetn,            // async reset, low active
   input  wire logic                  clk_en,             // freezes all state when low
   input  wire logic                  hsel,               // slave select
   input  wire logic [31:0]           haddr,              // byte address
   input  wire logic [1:0]            htrans,             // transfer type
   input  wire logic                  hwrite,             // write when high
   input  wire logic [2:0]            hsize,              // transfer size
   input  wire logic [31:0]           hwdata,             // write data
   input  wire logic                  hready,             // bus ready in
   output logic                       hreadyout,          // slave ready
   output logic                       hresp,              // always okay
   output logic [31:0]                hrdata,             // read data
   input  wire logic [MCU_ADDR_W-1:0] mcu_addr,           // host address pins
   input  wire logic                  code_fetch_strobe,  // host code fetch, high active
   input  wire logic                  mcu_read_strobe,    // host data read, high active
   input  wire logic                  mcu_write_strobe,   // host data write, high active
   input  wire logic                  on_backup_supply,   // switchover status pin
   output logic [NUM_MAIN-1:0]        main_sector_select, // main flash sector selects
   output logic [NUM_BOOT-1:0]        boot_sector_select, // boot flash sector selects
   output logic                       sram_select,        // sram select
   output logic                       io_select,          // io space select
   output logic                       periph_io_select,   // peripheral io select
   output logic                       battery_on_flag,    // running from battery
   output logic [BANK_W-1:0]          bank_bits           // bank bits to general logic array
);

   // register state
   logic [31:0]             window_cfg [NUM_WINDOWS];
   logic [NUM_WINDOWS-1:0]  win_enable;
   logic [7:0]              control;
   logic [BANK_W-1:0]       bank_reg;
   logic [7:0]              space_access_map;
   logic [7:0]              capacity_info_lo;
   logic [7:0]              boot_capacity_info;

   // bus state
   msm_bus_state_type       bus_state;
   logic [7:0]              bus_ofs;
   logic [31:0]             next_rdata;
   logic                    addr_phase;

   // pin synchronisers
   logic [MCU_ADDR_W-1:0]   addr_meta;
   logic [MCU_ADDR_W-1:0]   addr_sync;
   logic [2:0]              strobe_meta;
   logic [2:0]              strobe_sync;
   logic                    backup_meta;
   logic                    backup_sync;

   // decode nets
   logic                    code_cycle;
   logic                    data_cycle;
   logic [NUM_WINDOWS-1:0]  win_hit;
   logic [NUM_MAIN-1:0]     gated_main;
   logic [NUM_BOOT-1:0]     gated_boot;
   logic                    gated_sram;
   logic                    gated_io;
   logic                    gated_pio;
   logic [NUM_MAIN-1:0]     res_main;
   logic [NUM_BOOT-1:0]     res_boot;
   logic                    res_sram;
   logic                    res_io;
   logic                    res_pio;

   // read-only capacity contents
   assign capacity_info_lo   = {SRAM_SIZE_CODE, MAIN_SIZE_CODE};
   assign boot_capacity_info = {2'h0, BOOT_TYPE_CODE, BOOT_SIZE_CODE};

   // ---------------- ahb-lite slave ----------------

   assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= MSM_BUS_IDLE;
         bus_ofs   <= 8'h00;
      end else if (clk_en) begin
         if (addr_phase && hwrite) begin
            bus_state <= MSM_BUS_WRITE;
            bus_ofs   <= haddr[7:0];
         end else if (addr_phase) begin
            bus_state <= MSM_BUS_READ;
            bus_ofs   <= haddr[7:0];
         end else if (bus_state != MSM_BUS_READ) begin
            bus_state <= MSM_BUS_IDLE;
         end else begin
            bus_state <= MSM_BUS_IDLE;
         end
      end
   end

   // one wait state on reads so hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else if (clk_en) begin
         hresp <= HRESP_OKAY;
         if (addr_phase && !hwrite) begin
            hreadyout <= 1'b0;
         end else begin
            hreadyout <= 1'b1;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (bus_ofs < OFS_WIN_ENABLE && bus_ofs[1:0] == 2'h0) begin
         next_rdata = window_cfg[bus_ofs[WIN_INDEX_W+1:2]];
      end else begin
         case (bus_ofs)
            OFS_WIN_ENABLE: next_rdata = {15'h0000, win_enable};
            OFS_CONTROL:    next_rdata = {24'h00_0000, control};
            OFS_BANK:       next_rdata = {24'h00_0000, bank_reg};
            OFS_SPACE:      next_rdata = {24'h00_0000, space_access_map};
            OFS_CAP_LO:     next_rdata = {24'h00_0000, capacity_info_lo};
            OFS_BOOT_CAP:   next_rdata = {24'h00_0000, boot_capacity_info};
            default:        next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en && bus_state == MSM_BUS_READ) begin
         hrdata <= next_rdata;
      end
   end

   // ---------------- register writes ----------------

   genvar gw;
   generate
      for (gw = 0; gw < NUM_WINDOWS; gw++) begin : g_window
         localparam logic [7:0] WIN_OFS = OFS_WINDOW_BASE + 8'(gw * 4);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               window_cfg[gw] <= WINDOW_RESET;
            end else if (clk_en && bus_state == MSM_BUS_WRITE && bus_ofs == WIN_OFS) begin
               window_cfg[gw] <= hwdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_enable <= WIN_ENABLE_RESET;
         control    <= CONTROL_RESET;
      end else if (clk_en && bus_state == MSM_BUS_WRITE) begin
         if (bus_ofs == OFS_WIN_ENABLE) begin
            win_enable <= hwdata[NUM_WINDOWS-1:0];
         end
         if (bus_ofs == OFS_CONTROL) begin
            control <= hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_reg <= BANK_RESET;
      end else if (clk_en && bus_state == MSM_BUS_WRITE && bus_ofs == OFS_BANK) begin
         bank_reg <= hwdata[BANK_W-1:0];
      end
   end

   // boot value at reset, rewritable at any time; unused bits 6-5 stay zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         space_access_map <= SPACE_ACCESS_RESET;
      end else if (clk_en && bus_state == MSM_BUS_WRITE && bus_ofs == OFS_SPACE) begin
         space_access_map <= hwdata[7:0] & SPACE_USED_MASK;
      end
   end

   // ---------------- host pin synchronisers ----------------

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_meta   <= '0;
         addr_sync   <= '0;
         strobe_meta <= 3'h0;
         strobe_sync <= 3'h0;
         backup_meta <= 1'b0;
         backup_sync <= 1'b0;
      end else if (clk_en) begin
         addr_meta   <= mcu_addr;
         addr_sync   <= addr_meta;
         strobe_meta <= {mcu_write_strobe, mcu_read_strobe, code_fetch_strobe};
         strobe_sync <= strobe_meta;
         backup_meta <= on_backup_supply;
         backup_sync <= backup_meta;
      end
   end

   // a write is treated as a data space access
   assign code_cycle = strobe_sync[0];
   assign data_cycle = strobe_sync[1] | strobe_sync[2];

   // ---------------- decode array ----------------

   // each window compares high address byte and bank bits under care masks
   genvar gd;
   generate
      for (gd = 0; gd < NUM_WINDOWS; gd++) begin : g_decode
         logic addr_ok;
         logic bank_ok;
         assign addr_ok = ((addr_sync[15:8] ^ window_cfg[gd][WIN_ADDR_VAL_LSB +: 8])
                           & window_cfg[gd][WIN_ADDR_MASK_LSB +: 8]) == 8'h00;
         assign bank_ok = ((bank_reg ^ window_cfg[gd][WIN_BANK_VAL_LSB +: BANK_W])
                           & window_cfg[gd][WIN_BANK_MASK_LSB +: BANK_W]) == 8'h00;
         assign win_hit[gd] = win_enable[gd] & addr_ok & bank_ok;
      end
   endgenerate

   // space access gating: a memory absent from the current space cannot win
   always_comb begin
      gated_main = win_hit[WIN_MAIN_FIRST +: NUM_MAIN]
                   & {NUM_MAIN{(code_cycle & space_access_map[SPACE_MAIN_CODE_BIT])
                             | (data_cycle & space_access_map[SPACE_MAIN_DATA_BIT])}};
      gated_boot = win_hit[WIN_BOOT_FIRST +: NUM_BOOT]
                   & {NUM_BOOT{(code_cycle & space_access_map[SPACE_BOOT_CODE_BIT])
                             | (data_cycle & space_access_map[SPACE_BOOT_DATA_BIT])}};
      // any of the three sram terms selects sram
      gated_sram = (|win_hit[WIN_SRAM_FIRST +: NUM_SRAM_TERMS])
                   & ((code_cycle & space_access_map[SPACE_SRAM_CODE_BIT]) | data_cycle);
      gated_io   = win_hit[WIN_IO] & data_cycle;
      gated_pio  = win_hit[WIN_PIO] & data_cycle & space_access_map[SPACE_PERIPH_IO_ENABLE_BIT];
   end

   msm_priority u_priority (
      .raw_main (gated_main),
      .raw_boot (gated_boot),
      .raw_sram (gated_sram),
      .raw_io   (gated_io),
      .raw_pio  (gated_pio),
      .main_out (res_main),
      .boot_out (res_boot),
      .sram_out (res_sram),
      .io_out   (res_io),
      .pio_out  (res_pio)
   );

   // ---------------- registered outputs ----------------

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_sector_select <= '0;
         boot_sector_select <= '0;
         sram_select        <= 1'b0;
         io_select          <= 1'b0;
         periph_io_select   <= 1'b0;
      end else if (clk_en) begin
         main_sector_select <= res_main;
         boot_sector_select <= res_boot;
         sram_select        <= res_sram;
         io_select          <= res_io;
         periph_io_select   <= res_pio;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         battery_on_flag <= 1'b0;
      end else if (clk_en) begin
         battery_on_flag <= control[CTRL_BATTERY_EN_BIT] & backup_sync;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_bits <= BANK_RESET;
      end else if (clk_en) begin
         bank_bits <= bank_reg;
      end
   end

endmodule // msm_top

// ---- verilog/msm_pkg.sv ----
// msm_pkg: constants shared by the memory select mapping block
// assumes a 32-bit ahb-lite register bus and a 16-bit host address bus
package msm_pkg;

   // host bus and decode geometry
   localparam int MCU_ADDR_W      = 16;
   localparam int BANK_W          = 8;
   localparam int NUM_MAIN        = 8;
   localparam int NUM_BOOT        = 4;
   localparam int NUM_SRAM_TERMS  = 3;
   localparam int NUM_WINDOWS     = 17;
   localparam int WIN_MAIN_FIRST  = 0;
   localparam int WIN_BOOT_FIRST  = 8;
   localparam int WIN_SRAM_FIRST  = 12;
   localparam int WIN_IO          = 15;
   localparam int WIN_PIO         = 16;
   localparam int WIN_INDEX_W     = 5;

   // register byte offsets
   localparam logic [7:0] OFS_WINDOW_BASE = 8'h00;
   localparam logic [7:0] OFS_WIN_ENABLE  = 8'h44;
   localparam logic [7:0] OFS_CONTROL     = 8'h48;
   localparam logic [7:0] OFS_BANK        = 8'hE0;
   localparam logic [7:0] OFS_SPACE       = 8'hE4;
   localparam logic [7:0] OFS_CAP_LO      = 8'hE8;
   localparam logic [7:0] OFS_BOOT_CAP    = 8'hEC;

   // window register fields
   localparam int WIN_ADDR_MASK_LSB = 0;
   localparam int WIN_ADDR_VAL_LSB  = 8;
   localparam int WIN_BANK_MASK_LSB = 16;
   localparam int WIN_BANK_VAL_LSB  = 24;

   // space access fields
   localparam int SPACE_SRAM_CODE_BIT = 0;
   localparam int SPACE_BOOT_CODE_BIT = 1;
   localparam int SPACE_MAIN_CODE_BIT = 2;
   localparam int SPACE_BOOT_DATA_BIT = 3;
   localparam int SPACE_MAIN_DATA_BIT = 4;
   localparam int SPACE_PERIPH_IO_ENABLE_BIT    = 7;
   localparam logic [7:0] SPACE_USED_MASK = 8'h9F;

   // control fields
   localparam int CTRL_BATTERY_EN_BIT = 0;

   // reset values
   localparam logic [7:0]  SPACE_ACCESS_RESET = 8'h0C;
   localparam logic [7:0]  BANK_RESET         = 8'h00;
   localparam logic [31:0] WINDOW_RESET       = 32'h0000_0000;
   localparam logic [16:0] WIN_ENABLE_RESET   = 17'h0_0000;
   localparam logic [7:0]  CONTROL_RESET      = 8'h00;

   // capacity codes reported to software
   localparam logic [3:0] SRAM_SIZE_CODE = 4'h1;
   localparam logic [3:0] MAIN_SIZE_CODE = 4'h1;
   localparam logic [1:0] BOOT_TYPE_CODE = 2'h0;
   localparam logic [3:0] BOOT_SIZE_CODE = 4'h1;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef enum logic [1:0] {
      MSM_BUS_IDLE  = 2'b00,
      MSM_BUS_WRITE = 2'b01,
      MSM_BUS_READ  = 2'b11
   } msm_bus_state_type;

endpackage

// ---- verilog/msm_priority.sv ----
// msm_priority: resolves overlapping memory selects by level: level one, then boot, then main
// assumes raw selects are already gated by the space access settings
`timescale 1ns/1ps

module msm_priority
   import msm_pkg::*;
(
   input  wire logic [NUM_MAIN-1:0] raw_main,   // main sector hits
   input  wire logic [NUM_BOOT-1:0] raw_boot,   // boot sector hits
   input  wire logic                raw_sram,   // sram hit
   input  wire logic                raw_io,     // io space hit
   input  wire logic                raw_pio,    // peripheral io hit
   output logic      [NUM_MAIN-1:0] main_out,   // resolved main selects
   output logic      [NUM_BOOT-1:0] boot_out,   // resolved boot selects
   output logic                     sram_out,   // resolved sram select
   output logic                     io_out,     // resolved io select
   output logic                     pio_out     // resolved peripheral io select
);

   logic level_one_hit;
   logic level_two_hit;

   // level one: sram, io and peripheral io
   assign level_one_hit = raw_sram | raw_io | raw_pio;
   assign level_two_hit = |raw_boot;
   assign sram_out      = raw_sram;
   assign io_out        = raw_io;
   assign pio_out       = raw_pio;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BOOT; gi++) begin : g_boot
         assign boot_out[gi] = raw_boot[gi] & ~level_one_hit;
      end
      for (gi = 0; gi < NUM_MAIN; gi++) begin : g_main
         // boot beats main, level one beats both
         assign main_out[gi] = raw_main[gi] & ~level_two_hit & ~level_one_hit;
      end
   endgenerate

endmodule // msm_priority

// ---- verification/msm_top_assertions.sv ----
// msm_chk: bus timing, register content and select priority checks
// assumes hready is looped back from hreadyout and one ahb master
`timescale 1ns/1ps
module msm_chk
   import msm_pkg::*;
(
   input wire logic                hclk,               // clock
   input wire logic                hresetn,            // reset
   input wire logic                clk_en,             // run
   input wire logic                hsel,               // select
   input wire logic [31:0]         haddr,              // address
   input wire logic [1:0]          htrans,             // transfer
   input wire logic                hwrite,             // write
   input wire logic [31:0]         hwdata,             // write data
   input wire logic                hready,             // ready in
   input wire logic                hreadyout,          // ready out
   input wire logic [31:0]         hrdata,             // read data
   input wire logic                code_fetch_strobe,  // code strobe
   input wire logic                mcu_read_strobe,    // read strobe
   input wire logic                mcu_write_strobe,   // write strobe
   input wire logic                on_backup_supply,   // supply status
   input wire logic [NUM_MAIN-1:0] main_sector_select, // main selects
   input wire logic [NUM_BOOT-1:0] boot_sector_select, // boot selects
   input wire logic                sram_select,        // sram
   input wire logic                io_select,          // io
   input wire logic                periph_io_select,   // periph io
   input wire logic                battery_on_flag,    // battery
   input wire logic [BANK_W-1:0]   bank_bits           // bank copy
);
   logic       take;
   logic [7:0] ofs;
   logic [7:0] wlow;
   assign take = hsel && hready && clk_en && htrans == HTRANS_NONSEQ;
   assign ofs = haddr[7:0];
   assign wlow = hwdata[7:0];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_bank_copy: assert property (
      take && hwrite && ofs == OFS_BANK |=> ##2 bank_bits == $past(wlow, 2))
      else $error("bank copy wrong");
   a_cap_lo: assert property (
      take && !hwrite && ofs == OFS_CAP_LO |=> ##1 hrdata == 32'h0000_0011)
      else $error("capacity low wrong");
   a_boot_cap: assert property (
      take && !hwrite && ofs == OFS_BOOT_CAP |=> ##1 hrdata[31:6] == 26'h000_0000)
      else $error("boot capacity unused bits set");
   a_space_gap: assert property (
      take && !hwrite && ofs == OFS_SPACE |=> ##1 hrdata[6:5] == 2'h0)
      else $error("space unused bits set");
   a_boot_wins: assert property (boot_sector_select != '0 |-> main_sector_select == '0)
      else $error("main sector beside boot sector");
   a_near_wins: assert property (
      sram_select || io_select || periph_io_select
      |-> main_sector_select == '0 && boot_sector_select == '0)
      else $error("flash beside sram or io");
   a_idle_quiet: assert property (
      !(code_fetch_strobe || mcu_read_strobe || mcu_write_strobe) [*4]
      |-> {main_sector_select, boot_sector_select, sram_select, io_select,
           periph_io_select} == '0)
      else $error("select without strobe");
   a_batt_flag: assert property (battery_on_flag |-> $past(on_backup_supply, 3))
      else $error("battery flag without backup");
endmodule // msm_chk

bind msm_top msm_chk i_msm_chk (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hrdata, .code_fetch_strobe, .mcu_read_strobe,
   .mcu_write_strobe, .on_backup_supply, .main_sector_select, .boot_sector_select,
   .sram_select, .io_select, .periph_io_select, .battery_on_flag, .bank_bits);

// ---- verification/msm_host_model.sv ----
// msm_host_model: host bus presenting an address with one strobe at a time
// assumes the bench sets kind and address just after a rising edge
`timescale 1ns/1ps
module msm_host_model
   import msm_pkg::*;
(
   input wire logic [0:0]            hclk,              // clock
   input wire logic [1:0]            kind,              // 0 idle 1 code 2 read 3 write
   input wire logic [MCU_ADDR_W-1:0] addr,              // wanted address
   output logic     [MCU_ADDR_W-1:0] mcu_addr,          // address pins
   output logic                      code_fetch_strobe, // code fetch
   output logic                      mcu_read_strobe,   // data read
   output logic                      mcu_write_strobe   // data write
);
   initial begin
      mcu_addr = '0;
      code_fetch_strobe = 1'b0;
      mcu_read_strobe = 1'b0;
      mcu_write_strobe = 1'b0;
   end
   always @(posedge hclk) begin
      code_fetch_strobe <= kind == 2'h1;
      mcu_read_strobe <= kind == 2'h2;
      mcu_write_strobe <= kind == 2'h3;
      // released address wanders so a stale value never looks valid
      mcu_addr <= (kind != 2'h0) ? addr : ~mcu_addr;
   end
endmodule // msm_host_model

// ---- verification/tb.sv ----
// tb: self-checking bench for the memory select mapping block
// assumes one ahb-lite master with hready looped back, host bus from msm_host_model
`timescale 1ns/1ps
`define CHK(n, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("FAIL %s exp %h got %h", n, e, g); \
      end \
   end
module tb
   import msm_pkg::*;
;
   localparam logic [14:0] S_MAIN0 = 15'h0080, S_MAIN1 = 15'h0100, S_BOOT0 = 15'h0008;
   localparam logic [14:0] S_SRAM = 15'h0004, S_IO = 15'h0002, S_PIO = 15'h0001;
   localparam logic [1:0]  K_CODE = 2'h1, K_RD = 2'h2, K_WR = 2'h3;
   logic                hclk, hresetn, hsel, hwrite, on_backup, hreadyout, hresp, run;
   logic                sram_select, io_select, periph_io_select, battery_on_flag;
   logic                code_fetch_strobe, mcu_read_strobe, mcu_write_strobe;
   logic [31:0]         haddr, hwdata, hrdata;
   logic [1:0]          htrans, kind;
   logic [15:0]         addr, mcu_addr;
   logic [NUM_MAIN-1:0] main_sector_select;
   logic [NUM_BOOT-1:0] boot_sector_select;
   logic [BANK_W-1:0]   bank_bits;
   logic [14:0]         sel;
   int                  error_cnt = 0;
   int                  num_checks = 0;
   assign sel = {main_sector_select, boot_sector_select, sram_select, io_select,
                 periph_io_select};

   msm_top i_msm_top (.hclk(hclk), .hresetn(hresetn), .clk_en(run), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mcu_addr(mcu_addr), .code_fetch_strobe(code_fetch_strobe),
      .mcu_read_strobe(mcu_read_strobe), .mcu_write_strobe(mcu_write_strobe),
      .on_backup_supply(on_backup), .main_sector_select(main_sector_select),
      .boot_sector_select(boot_sector_select), .sram_select(sram_select),
      .io_select(io_select), .periph_io_select(periph_io_select),
      .battery_on_flag(battery_on_flag), .bank_bits(bank_bits));
   msm_host_model i_msm_host_model (.hclk(hclk), .kind(kind), .addr(addr),
      .mcu_addr(mcu_addr), .code_fetch_strobe(code_fetch_strobe),
      .mcu_read_strobe(mcu_read_strobe), .mcu_write_strobe(mcu_write_strobe));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0000_0000, q);
      `CHK("register", e, q);
      `CHK("hresp", HRESP_OKAY, hresp);
   endtask
   // present one host cycle, judge the selects, then judge them idle
   task automatic probe(input logic [1:0] k, input logic [15:0] a, input logic [14:0] e);
      @(posedge hclk);
      kind <= k;
      addr <= a;
      repeat (6) @(posedge hclk);
      `CHK("selects", e, sel);
      kind <= 2'h0;
      repeat (6) @(posedge hclk);
      `CHK("idle selects", 15'h0000, sel);
   endtask

   task automatic t_reset_values;
      rchk(OFS_BANK, 32'h0000_0000);
      rchk(OFS_SPACE, 32'h0000_000C);
      rchk(OFS_CAP_LO, 32'h0000_0011);
      rchk(OFS_BOOT_CAP, 32'h0000_0001);
      rchk(8'hF0, 32'h0000_0000);
   endtask
   task automatic t_registers;
      wr(OFS_BANK, 32'hFFFF_FF5A);
      rchk(OFS_BANK, 32'h0000_005A);
      `CHK("bank bits", 8'h5A, bank_bits);
      wr(OFS_CAP_LO, 32'hFFFF_FFFF);
      wr(OFS_BOOT_CAP, 32'hFFFF_FFFF);
      rchk(OFS_CAP_LO, 32'h0000_0011);
      rchk(OFS_BOOT_CAP, 32'h0000_0001);
      wr(OFS_SPACE, 32'hFFFF_FFFF);
      rchk(OFS_SPACE, 32'h0000_009F);
      wr(OFS_BANK, 32'h0000_0000);
   endtask
   task automatic t_priority;
      wr(8'h00, 32'h0000_80C0); // main sector 0 over 8000-BFFF
      wr(8'h04, 32'h03FF_10F0); // main sector 1 over 1000-1FFF on bank 03
      wr(8'h20, 32'h0000_80E0); // boot sector 0 over 8000-9FFF
      wr(8'h30, 32'h0000_80F8); // sram over 8000-87FF
      wr(8'h38, 32'h0000_B0FF); // third sram term over B000-B0FF
      wr(8'h3C, 32'h0000_88FF); // io over 8800-88FF
      wr(8'h40, 32'h0000_90FF); // peripheral io over 9000-90FF
      wr(OFS_WIN_ENABLE, 32'h0001_D103);
      probe(K_RD, 16'h8400, S_SRAM);
      probe(K_RD, 16'hB010, S_SRAM);
      probe(K_RD, 16'h9800, S_BOOT0);
      probe(K_WR, 16'h8840, S_IO);
      probe(K_RD, 16'h9010, S_PIO);
      probe(K_RD, 16'hA000, S_MAIN0);
      probe(K_RD, 16'hC000, 15'h0000);
   endtask
   task automatic t_space;
      wr(OFS_SPACE, 32'h0000_000C);
      probe(K_CODE, 16'hA000, S_MAIN0);
      probe(K_RD, 16'hA000, 15'h0000);
      probe(K_CODE, 16'h8400, S_MAIN0);
      probe(K_RD, 16'h8400, S_SRAM);
      probe(K_RD, 16'h9010, S_BOOT0);
      wr(OFS_SPACE, 32'h0000_0014);
      probe(K_CODE, 16'hA000, S_MAIN0);
      probe(K_RD, 16'hA000, S_MAIN0);
      probe(K_CODE, 16'h9800, S_MAIN0);
   endtask
   task automatic t_bank_decode;
      probe(K_RD, 16'h1000, 15'h0000);
      wr(OFS_BANK, 32'h0000_0003);
      probe(K_RD, 16'h1000, S_MAIN1);
      wr(OFS_BANK, 32'h0000_0007);
      probe(K_RD, 16'h1000, 15'h0000);
      `CHK("bank bits", 8'h07, bank_bits);
   endtask
   task automatic t_battery;
      @(posedge hclk);
      on_backup <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK("battery flag", 1'b0, battery_on_flag);
      wr(OFS_CONTROL, 32'h0000_0001);
      repeat (4) @(posedge hclk);
      `CHK("battery flag", 1'b1, battery_on_flag);
      on_backup <= 1'b0;
      repeat (6) @(posedge hclk);
      `CHK("battery flag", 1'b0, battery_on_flag);
   endtask
   // clock enable low must hold the flag although the supply pin moves
   task automatic t_freeze;
      @(posedge hclk);
      run <= 1'b0;
      on_backup <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK("frozen flag", 1'b0, battery_on_flag);
      run <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK("battery flag", 1'b1, battery_on_flag);
      on_backup <= 1'b0;
      repeat (6) @(posedge hclk);
   endtask

   task automatic final_report;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      kind = 2'h0;
      addr = 16'h0000;
      on_backup = 1'b0;
      run = 1'b1;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values;
      t_registers;
      t_priority;
      t_space;
      t_bank_decode;
      t_battery;
      t_freeze;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      final_report;
   end
endmodule // tb
